//--- logic/fms_pkg.sv
package fms_pkg;
	// command codes of the three registers in this bank
	localparam logic [7:0] FMS_CMD_FAULT_ALERT_MASK = 8'hFA;
	localparam logic [7:0] FMS_CMD_GENERAL_STATUS = 8'hFB;
	localparam logic [7:0] FMS_CMD_PHASE_ENABLE_STATUS = 8'hFC;
	// reset values
	localparam logic [7:0] FMS_FAULT_ALERT_MASK_RST = 8'h00;
	localparam logic [7:0] FMS_GENERAL_STATUS_RST = 8'h10;
	localparam logic [7:0] FMS_PHASE_ENABLE_STATUS_RST = 8'h00;
	// fault mask fields
	localparam int FMS_OVERVOLTAGE_ALERT_SUPPRESS_BIT = 7;
	localparam int FMS_OVERCURRENT_ALERT_SUPPRESS_BIT = 6;
	// general status fields
	localparam int FMS_GS_ALERT_BIT = 6;
	localparam int FMS_GS_POWER_GOOD_BIT = 5;
	localparam int FMS_GS_READY_BIT = 4;
	// phase status fields: phase n sits at bit n-1
	localparam int FMS_PHASE_COUNT = 6;
	localparam int FMS_PHASE_LSB = 0;
	// value read from an unmapped command code
	localparam logic [7:0] FMS_UNMAPPED_READ = 8'h00;
	// default 7-bit bus address, a plain choice
	localparam logic [6:0] FMS_BUS_ADDR_DEFAULT = 7'h20;
	// bits per byte on the bus, minus one
	localparam logic [2:0] FMS_LAST_BIT = 3'h7;
	// byte roles while receiving
	typedef enum logic [1:0] {
		FMS_RX_ADDR = 2'h0,
		FMS_RX_CMD = 2'h1,
		FMS_RX_DATA = 2'h2
	} fms_rx_kind_e;
	// bus slave states, one-hot
	typedef enum logic [4:0] {
		FMS_ST_IDLE = 5'h01,
		FMS_ST_RX = 5'h02,
		FMS_ST_ACK = 5'h04,
		FMS_ST_TX = 5'h08,
		FMS_ST_MACK = 5'h10
	} fms_state_e;
endpackage

//--- logic/fms_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser, one lane per bit
module fms_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			logic meta_reg;
			logic stable_reg;
			// first flop feeds only the second
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					meta_reg <= RST_VAL[i];
					stable_reg <= RST_VAL[i];
				end else begin
					meta_reg <= async_in[i];
					stable_reg <= meta_reg;
				end
			end
			assign sync_out[i] = stable_reg;
		end
	endgenerate
endmodule

//--- logic/fms_regs.sv
`timescale 1ns/10ps
// Function
// - fault mask bit 7 set stops over-voltage events from raising the alert.
// - fault mask bit 6 set stops over-current events from raising the alert.
// - general status shows alert bit 6, power-good bit 5, ready bit 4.
// - phase status bits 0..2 are one while phases one..three are enabled.
// - phase status bits 3..5 follow phases four..six; bits 7 and 6 reserved.
module fms_regs
	import fms_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = fms_pkg::FMS_BUS_ADDR_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_pin,
	input wire logic sda_pin_in,
	output logic sda_pin_out,
	output logic sda_pin_oe_n,
	input wire logic ovp_event,
	input wire logic ocp_event,
	input wire logic power_good,
	input wire logic ready,
	input wire logic [fms_pkg::FMS_PHASE_COUNT-1:0] phase_enable,
	output logic alert_n
);
	import fms_pkg::*;

	logic [1:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	fms_state_e state_reg;
	fms_rx_kind_e rx_kind_reg;
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic byte_full_reg;
	logic rw_reg;
	logic addr_hit_reg;
	logic [7:0] cmd_reg;
	logic drive_low_reg;
	logic master_nack_reg;
	logic [7:0] fault_alert_mask_reg;
	logic [7:0] general_status_reg;
	logic [7:0] phase_enable_status_reg;
	logic alert_reg;
	logic alert_next;
	logic [7:0] read_data;
	logic mask_write;

	// bus pins come from outside the clock domain
	fms_sync #(
		.WIDTH(2),
		.RST_VAL(2'h3)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in({scl_pin, sda_pin_in}),
		.sync_out(pins_sync)
	);
	assign scl_s = pins_sync[1];
	assign sda_s = pins_sync[0];

	// edge history of the synchronised pins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	// sda moving while scl is high frames a transfer
	assign scl_rise = scl_s & ~scl_prev_reg;
	assign scl_fall = ~scl_s & scl_prev_reg;
	assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	assign bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

	// read mux; unmapped codes read as zero rather than stalling the bus
	always_comb begin
		case (cmd_reg)
			FMS_CMD_FAULT_ALERT_MASK: read_data = fault_alert_mask_reg;
			FMS_CMD_GENERAL_STATUS: read_data = general_status_reg;
			FMS_CMD_PHASE_ENABLE_STATUS: read_data = phase_enable_status_reg;
			default: read_data = FMS_UNMAPPED_READ;
		endcase
	end

	// a data byte lands only on the mask code; status codes ignore it
	assign mask_write = (state_reg == FMS_ST_RX) && scl_fall && byte_full_reg &&
		(rx_kind_reg == FMS_RX_DATA) && (cmd_reg == FMS_CMD_FAULT_ALERT_MASK);

	// bus slave sequencing: bits sampled on scl rise, sda changed on scl fall
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= FMS_ST_IDLE;
			rx_kind_reg <= FMS_RX_ADDR;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			byte_full_reg <= 1'b0;
			rw_reg <= 1'b0;
			addr_hit_reg <= 1'b0;
			cmd_reg <= 8'h00;
			drive_low_reg <= 1'b0;
			master_nack_reg <= 1'b0;
		end else if (bus_stop) begin
			state_reg <= FMS_ST_IDLE;
			drive_low_reg <= 1'b0;
		end else if (bus_start) begin
			// repeated start keeps the command code for the read that follows
			state_reg <= FMS_ST_RX;
			rx_kind_reg <= FMS_RX_ADDR;
			bit_cnt_reg <= 3'h0;
			byte_full_reg <= 1'b0;
			drive_low_reg <= 1'b0;
		end else begin
			case (state_reg)
				FMS_ST_IDLE: begin
					drive_low_reg <= 1'b0;
				end
				FMS_ST_RX: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						byte_full_reg <= (bit_cnt_reg == FMS_LAST_BIT);
					end else if (scl_fall && byte_full_reg) begin
						byte_full_reg <= 1'b0;
						if (rx_kind_reg == FMS_RX_ADDR) begin
							if (shift_reg[7:1] == BUS_ADDR) begin
								rw_reg <= shift_reg[0];
								addr_hit_reg <= 1'b1;
								drive_low_reg <= 1'b1;
								state_reg <= FMS_ST_ACK;
							end else begin
								// not ours: stay off the bus until the next start
								addr_hit_reg <= 1'b0;
								state_reg <= FMS_ST_IDLE;
							end
						end else begin
							if (rx_kind_reg == FMS_RX_CMD) begin
								cmd_reg <= shift_reg;
							end
							drive_low_reg <= 1'b1;
							state_reg <= FMS_ST_ACK;
						end
					end
				end
				FMS_ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 3'h0;
						if (rw_reg) begin
							shift_reg <= {read_data[6:0], 1'b0};
							drive_low_reg <= ~read_data[7];
							state_reg <= FMS_ST_TX;
						end else begin
							drive_low_reg <= 1'b0;
							rx_kind_reg <= (rx_kind_reg == FMS_RX_ADDR) ?
								FMS_RX_CMD : FMS_RX_DATA;
							state_reg <= FMS_ST_RX;
						end
					end
				end
				FMS_ST_TX: begin
					if (scl_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						byte_full_reg <= (bit_cnt_reg == FMS_LAST_BIT);
					end else if (scl_fall) begin
						if (byte_full_reg) begin
							byte_full_reg <= 1'b0;
							drive_low_reg <= 1'b0; // release for the host's ack bit
							state_reg <= FMS_ST_MACK;
						end else begin
							drive_low_reg <= ~shift_reg[7];
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
				end
				FMS_ST_MACK: begin
					if (scl_rise) begin
						master_nack_reg <= sda_s;
					end else if (scl_fall) begin
						if (master_nack_reg) begin
							state_reg <= FMS_ST_IDLE;
						end else begin
							// further reads repeat the same one-byte register
							bit_cnt_reg <= 3'h0;
							shift_reg <= {read_data[6:0], 1'b0};
							drive_low_reg <= ~read_data[7];
							state_reg <= FMS_ST_TX;
						end
					end
				end
				default: begin
					state_reg <= FMS_ST_IDLE;
					drive_low_reg <= 1'b0;
				end
			endcase
		end
	end

	// open-drain data pin: only ever pulls low
	assign sda_pin_out = 1'b0;
	assign sda_pin_oe_n = ~drive_low_reg;

	// writable fault mask; reserved low bits are stored as written
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fault_alert_mask_reg <= FMS_FAULT_ALERT_MASK_RST;
		end else if (mask_write) begin
			fault_alert_mask_reg <= shift_reg;
		end
	end

	// alert follows unmasked faults; a masked fault never reaches the pin
	always_comb begin
		alert_next = 1'b0;
		if (ovp_event && !fault_alert_mask_reg[FMS_OVERVOLTAGE_ALERT_SUPPRESS_BIT]) begin
			alert_next = 1'b1;
		end
		if (ocp_event && !fault_alert_mask_reg[FMS_OVERCURRENT_ALERT_SUPPRESS_BIT]) begin
			alert_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alert_reg <= 1'b0;
		end else begin
			alert_reg <= alert_next;
		end
	end

	assign alert_n = ~alert_reg;

	// status snapshots, refreshed every cycle from the regulator logic only
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			general_status_reg <= FMS_GENERAL_STATUS_RST;
		end else begin
			general_status_reg <= 8'h00;
			general_status_reg[FMS_GS_ALERT_BIT] <= alert_next;
			general_status_reg[FMS_GS_POWER_GOOD_BIT] <= power_good;
			general_status_reg[FMS_GS_READY_BIT] <= ready;
		end
	end

	// one status bit per phase; reserved top bits stay zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_enable_status_reg <= FMS_PHASE_ENABLE_STATUS_RST;
		end else begin
			phase_enable_status_reg <= 8'h00;
			phase_enable_status_reg[FMS_PHASE_LSB +: FMS_PHASE_COUNT] <= phase_enable;
		end
	end
endmodule

//--- bench/fms_regs_chk.sv
`timescale 1ns/10ps
// port-level watch; the mask itself is hidden, so alert is tied to its causes
module fms_regs_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_pin,
	input wire logic sda_pin_in,
	input wire logic sda_pin_oe_n,
	input wire logic ovp_event,
	input wire logic ocp_event,
	input wire logic alert_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_start;
		scl_pin && $fell(sda_pin_in);
	endsequence
	sequence s_scl_fall;
		$fell(scl_pin);
	endsequence
	a_alert_cause: assert property (
		!alert_n |-> $past(ovp_event || ocp_event)) else $error("alert low without fault");
	a_alert_quiet: assert property (
		!(ovp_event || ocp_event) |=> alert_n) else $error("alert low after faults cleared");
	a_alert_steady: assert property (
		scl_pin && $stable({ovp_event, ocp_event}) && !$past(rst) |=> $stable(alert_n))
		else $error("alert moved with steady faults");
	a_oe_scl_low: assert property (
		$changed(sda_pin_oe_n) |-> !scl_pin) else $error("data line moved while clock high");
	a_fall_hold: assert property (
		s_scl_fall |-> $stable(sda_pin_oe_n) [*2]) else $error("data line moved too early");
	a_start_quiet: assert property (
		s_start |-> sda_pin_oe_n [*8]) else $error("device drove line after start");
endmodule
bind fms_regs fms_regs_chk i_fms_regs_chk (.ref_clk, .rst, .scl_pin, .sda_pin_in,
	.sda_pin_oe_n, .ovp_event, .ocp_event, .alert_n);

//--- bench/fms_host.sv
`timescale 1ns/10ps
// bus host; lines pulled up, so a released line reads high
module fms_host (
	input wire logic ref_clk,
	input wire logic sda_dev_n,
	input wire logic sda_dev_out,
	output logic scl,
	output logic sda
);
	logic sda_drv_n = 1'h1;
	initial scl = 1'h1;
	// wired-and of both drivers; an enabled device shows its driven level, not a forced zero
	assign sda = sda_drv_n & (sda_dev_n | sda_dev_out);
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// data moves 4 cycles after the clock falls, past the device's sync delay
	task automatic bit_io(input logic b, output logic r);
		wt(4);
		sda_drv_n = b;
		wt(4);
		scl = 1'h1;
		wt(4);
		r = sda;
		wt(4);
		scl = 1'h0;
	endtask
	// ninth bit n: released for the device's ack, or our ack (0) / nack (1) on reads
	task automatic byte_io(input logic [7:0] d, input logic n, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(n, a);
	endtask
	task automatic start();
		wt(4);
		sda_drv_n = 1'h1;
		wt(4);
		scl = 1'h1;
		wt(6);
		sda_drv_n = 1'h0;
		wt(6);
		scl = 1'h0;
	endtask
	task automatic stop();
		wt(4);
		sda_drv_n = 1'h0;
		wt(4);
		scl = 1'h1;
		wt(6);
		sda_drv_n = 1'h1;
		wt(6);
	endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/10ps
module tb;
	import fms_pkg::*;
	logic ref_clk = 1'h0, rst = 1'h1, scl, sda, sda_pin_out, sda_pin_oe_n, alert_n;
	logic ovp_event = 1'h0, ocp_event = 1'h0, power_good = 1'h0, ready = 1'h1;
	logic [5:0] phase_enable = 6'h00;
	logic [7:0] exp_q[$], got_q[$];
	int fails = 0, n_compared = 0, seed = 82889;
	always #50 ref_clk = ~ref_clk;
	fms_regs i_fms_regs (.ref_clk, .rst, .scl_pin(scl), .sda_pin_in(sda), .sda_pin_out,
		.sda_pin_oe_n, .ovp_event, .ocp_event, .power_good, .ready, .phase_enable, .alert_n);
	fms_host i_fms_host (.ref_clk, .sda_dev_n(sda_pin_oe_n), .sda_dev_out(sda_pin_out), .scl,
		.sda);
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// every byte the host sends is answered with the expected ack level e
	task automatic put(input logic [7:0] d, input logic e);
		logic [7:0] q;
		logic a;
		i_fms_host.byte_io(d, 1'h1, q, a);
		exp_q.push_back({7'h00, e});
		got_q.push_back({7'h00, a});
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		i_fms_host.start();
		put({FMS_BUS_ADDR_DEFAULT, 1'h0}, 1'h0);
		put(c, 1'h0);
		put(d, 1'h0);
		i_fms_host.stop();
	endtask
	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		logic [7:0] q;
		logic a;
		i_fms_host.start();
		put({FMS_BUS_ADDR_DEFAULT, 1'h0}, 1'h0);
		put(c, 1'h0);
		i_fms_host.start();
		put({FMS_BUS_ADDR_DEFAULT, 1'h1}, 1'h0);
		exp_q.push_back(e);
		i_fms_host.byte_io(8'hFF, 1'h1, q, a);
		got_q.push_back(q);
		i_fms_host.stop();
	endtask
	// results are paired with the oldest expectation as they arrive
	always begin
		wait (got_q.size() > 0);
		check(got_q.pop_front(), exp_q.pop_front());
	end
	// about 49k cycles expected; this leaves ample margin
	initial begin
		#8ms;
		fails++;
		give_verdict();
	end
	// every mask pair against every fault pair, status inputs random
	initial begin
		logic [7:0] m;
		logic al;
		logic [7:0] q;
		logic a;
		repeat (8) @(negedge ref_clk);
		rst = 1'h0;
		repeat (4) @(negedge ref_clk);
		rd(FMS_CMD_GENERAL_STATUS, 8'h10);
		rd(8'hF9, FMS_UNMAPPED_READ);
		for (int i = 0; i < 16; i++) begin
			m = {i[3:2], 6'($random(seed))};
			wr(FMS_CMD_FAULT_ALERT_MASK, m);
			wr(i[0] ? FMS_CMD_GENERAL_STATUS : FMS_CMD_PHASE_ENABLE_STATUS, 8'($random(seed)));
			{power_good, ready, phase_enable} = 8'($random(seed));
			{ovp_event, ocp_event} = i[1:0];
			al = (ovp_event & ~m[7]) | (ocp_event & ~m[6]);
			repeat (2) @(negedge ref_clk);
			exp_q.push_back({7'h00, al});
			got_q.push_back({7'h00, ~alert_n});
			rd(FMS_CMD_FAULT_ALERT_MASK, m);
			rd(FMS_CMD_GENERAL_STATUS, {1'h0, al, power_good, ready, 4'h0});
			rd(FMS_CMD_PHASE_ENABLE_STATUS, {2'h0, phase_enable});
		end
		// a foreign address gets no ack, and the bytes after it leave the mask alone
		i_fms_host.start();
		put({FMS_BUS_ADDR_DEFAULT ^ 7'h01, 1'h0}, 1'h1);
		put(FMS_CMD_FAULT_ALERT_MASK, 1'h1);
		put(~m, 1'h1);
		i_fms_host.stop();
		rd(FMS_CMD_FAULT_ALERT_MASK, m);
		// host acks the first byte, so the same one-byte register is sent again
		i_fms_host.start();
		put({FMS_BUS_ADDR_DEFAULT, 1'h0}, 1'h0);
		put(FMS_CMD_PHASE_ENABLE_STATUS, 1'h0);
		i_fms_host.start();
		put({FMS_BUS_ADDR_DEFAULT, 1'h1}, 1'h0);
		for (int k = 0; k < 2; k++) begin
			exp_q.push_back({2'h0, phase_enable});
			i_fms_host.byte_io(8'hFF, k[0], q, a);
			got_q.push_back(q);
		end
		i_fms_host.stop();
		give_verdict();
	end
endmodule
